//--- hw/event_link_pkg.sv
package event_link_pkg;

  // ---------------------------------------------------------------
  // Destination select field
  // ---------------------------------------------------------------
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned NUM_SRC = 26;
  localparam int unsigned NUM_DST = 11;

  localparam logic [3:0] DEST_OFF   = 4'h0;
  localparam logic [3:0] DEST_ADC   = 4'h1;
  localparam logic [3:0] DEST_CH0   = 4'h2;
  localparam logic [3:0] DEST_CH1   = 4'h3;
  localparam logic [3:0] DEST_CSRC  = 4'h4;
  localparam logic [3:0] DEST_CAPA  = 4'h5;
  localparam logic [3:0] DEST_CAPB  = 4'h6;
  localparam logic [3:0] DEST_DAC   = 4'h7;
  localparam logic [3:0] DEST_CH2   = 4'h8;
  localparam logic [3:0] DEST_CH3   = 4'h9;
  localparam logic [3:0] DEST_PWM   = 4'hA;

  // Source slot carrying the channel 0 count-end event
  localparam int unsigned SRC_CH0_END = 14;

  // ---------------------------------------------------------------
  // Timer channels
  // ---------------------------------------------------------------
  localparam int unsigned TIMER_W   = 16;
  localparam int unsigned NUM_CHAN  = 2;
  localparam logic        MODE_INTERVAL = 1'b0;
  localparam logic        MODE_EVENT    = 1'b1;

  // Worst-case detection figures, in destination clock cycles
  localparam int unsigned CHAN_DETECT_MAX = 4;
  localparam int unsigned CAP_DETECT_MAX  = 3;
  localparam int unsigned DAC_DETECT_MAX  = 2;
  localparam int unsigned PWM_DETECT_MAX  = 2;

endpackage

//--- hw/event_link_router.sv
`timescale 1ns/10ps

// Summary of operation
// - Cascade: channel 0 is low half; its underflow decrements channel 1.
// - Channel 0 interval timer end event routes to channel 1 event counter.
// - Edge events decrement channel 0; one end pulse after preset count.
// - Converter trigger is the routed event itself, no added cycles.
// - Timer channels 0 to 3 see routed events within four system cycles.
// - Count-source timer takes the routed event directly as count source.
// - Capture timers detect routed events within three own-clock cycles.
// - Analogue output detects within two cycles, starts on the next one.
// - PWM cutoff detects within two cycles, cutoff state begins next cycle.
// - Four-bit select per source; zero disables, one picks converter.
module event_link_router #(
  parameter int unsigned NUM_SRC = event_link_pkg::NUM_SRC,
  parameter int unsigned TIMER_W = event_link_pkg::TIMER_W
) (
  input  wire logic                                      sys_clk,
  input  wire logic                                      rst,
  input  wire logic [NUM_SRC-1:0]                        srcEvent,
  input  wire logic [NUM_SRC*event_link_pkg::SEL_W-1:0]  destSel,
  input  wire logic                                      tauTick,
  input  wire logic [1:0]                                chanEnable,
  input  wire logic [1:0]                                chanMode,
  input  wire logic [2*TIMER_W-1:0]                      chanReload,
  input  wire logic                                      capClkEn,
  input  wire logic                                      pwmCutoffClear,
  output logic [NUM_SRC-1:0]                             srcIrq_q,
  output logic                                           adcTrigger,
  output logic                                           countSourceEvent,
  output logic [3:0]                                     chanEvent_q,
  output logic [1:0]                                     capEvent_q,
  output logic                                           dacStart_q,
  output logic                                           pwmCutoff_q,
  output logic [2*TIMER_W-1:0]                           chanCount_q,
  output logic [1:0]                                     chanEnd_q
);

  localparam int unsigned SW = event_link_pkg::SEL_W;
  localparam int unsigned ND = event_link_pkg::NUM_DST;
  localparam int unsigned NC = 2;
  localparam int unsigned NT = event_link_pkg::NUM_CHAN;

  typedef struct packed {
    logic [NUM_SRC-1:0]            irq;
    logic [3:0]                    chanPipe;
    logic [3:0]                    chanDet;
    logic [1:0]                    capPend;
    logic [1:0]                    capDet;
    logic                          dacDet;
    logic                          dacStart;
    logic                          pwmDet;
    logic                          pwmCut;
    logic [1:0][TIMER_W-1:0]       cnt;
    logic [1:0]                    chEnd;
  } state_t;

  state_t stQ;
  state_t stD;

  // ---------------------------------------------------------------
  // Destination decode
  // ---------------------------------------------------------------
  function automatic logic [ND-1:0] route_hits(
    input logic [NUM_SRC-1:0]    ev,
    input logic [NUM_SRC*SW-1:0] sel
  );
    logic [ND-1:0] hits;
    logic [SW-1:0] code;
    hits = '0;
    for (int n = 0; n < NUM_SRC; n++) begin
      code = sel[n*SW +: SW];
      if (ev[n] && code != event_link_pkg::DEST_OFF &&
          code <= event_link_pkg::DEST_PWM) begin
        hits[code[3:0]] = 1'b1;
      end
    end
    return hits;
  endfunction

  // ---------------------------------------------------------------
  // Down-count step
  // ---------------------------------------------------------------
  // Zero reloads and raises the end flag in the top bit
  function automatic logic [TIMER_W:0] count_step(
    input logic [TIMER_W-1:0] cur,
    input logic [TIMER_W-1:0] reload
  );
    logic [TIMER_W:0] res;
    if (cur == '0) begin
      res = {1'b1, reload};
    end else begin
      res = {1'b0, cur - 1'b1};
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Live events and per-destination hits
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] liveEvent;
  logic [ND-1:0]      hit;
  logic [3:0]         chanHit;

  always_comb begin
    liveEvent = srcEvent;
    // end event feeds its source slot
    liveEvent[event_link_pkg::SRC_CH0_END] =
      srcEvent[event_link_pkg::SRC_CH0_END] | stQ.chEnd[0];
    hit = route_hits(liveEvent, destSel);
    chanHit[0] = hit[event_link_pkg::DEST_CH0];
    chanHit[1] = hit[event_link_pkg::DEST_CH1];
    chanHit[2] = hit[event_link_pkg::DEST_CH2];
    chanHit[3] = hit[event_link_pkg::DEST_CH3];
  end

  // ---------------------------------------------------------------
  // Direct destinations
  // ---------------------------------------------------------------
  // direct trigger
  assign adcTrigger       = hit[event_link_pkg::DEST_ADC];
  assign countSourceEvent = hit[event_link_pkg::DEST_CSRC];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic dec;

  always_comb begin
    stD = stQ;
    dec = 1'b0;

    // -------------------------------------------------------------
    // Interrupt copies
    // -------------------------------------------------------------
    // independent interrupt path
    stD.irq = liveEvent;

    // -------------------------------------------------------------
    // Channel detection
    // -------------------------------------------------------------
    // two-stage detection
    stD.chanPipe = chanHit;
    stD.chanDet  = stQ.chanPipe;

    // -------------------------------------------------------------
    // Capture timers
    // -------------------------------------------------------------
    // held until next capture clock
    for (int c = 0; c < NC; c++) begin
      if (capClkEn) begin
        stD.capDet[c]  = stQ.capPend[c] | hit[event_link_pkg::DEST_CAPA + c];
        stD.capPend[c] = 1'b0;
      end else begin
        stD.capDet[c]  = 1'b0;
        stD.capPend[c] = stQ.capPend[c] |
                         hit[event_link_pkg::DEST_CAPA + c];
      end
    end

    // -------------------------------------------------------------
    // Converter start and PWM cutoff
    // -------------------------------------------------------------
    // detect then start
    stD.dacDet   = hit[event_link_pkg::DEST_DAC];
    stD.dacStart = stQ.dacDet;

    stD.pwmDet = hit[event_link_pkg::DEST_PWM];
    if (stQ.pwmDet) begin
      stD.pwmCut = 1'b1;
    end else if (pwmCutoffClear) begin
      stD.pwmCut = 1'b0;
    end

    // -------------------------------------------------------------
    // Timer channels 0 and 1
    // -------------------------------------------------------------
    for (int i = 0; i < NT; i++) begin
      stD.chEnd[i] = 1'b0;
      if (chanMode[i] == event_link_pkg::MODE_INTERVAL) begin
        dec = tauTick;
      end else begin
        dec = stQ.chanDet[i];
      end
      if (!chanEnable[i]) begin
        stD.cnt[i] = chanReload[i*TIMER_W +: TIMER_W];
      end else if (dec) begin
        // single end pulse per preset run
        {stD.chEnd[i], stD.cnt[i]} =
          count_step(stQ.cnt[i], chanReload[i*TIMER_W +: TIMER_W]);
      end
    end

    // -------------------------------------------------------------
    // Synchronous reset
    // -------------------------------------------------------------
    if (rst) begin
      stD = '0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    stQ <= stD;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign srcIrq_q    = stQ.irq;
  assign chanEvent_q = stQ.chanDet;
  assign capEvent_q  = stQ.capDet;
  assign dacStart_q  = stQ.dacStart;
  assign pwmCutoff_q = stQ.pwmCut;
  assign chanCount_q = stQ.cnt;
  assign chanEnd_q   = stQ.chEnd;

endmodule

//--- tb/event_link_router_chk.sv
`timescale 1ns/10ps
module event_link_router_chk #(
  parameter int unsigned NUM_SRC = 26,
  parameter int unsigned TIMER_W = 16
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic [NUM_SRC-1:0]     srcEvent,
  input wire logic [NUM_SRC*4-1:0]   destSel,
  input wire logic                   capClkEn,
  input wire logic [2*TIMER_W-1:0]   chanReload,
  input wire logic [NUM_SRC-1:0]     srcIrq_q,
  input wire logic                   adcTrigger,
  input wire logic                   countSourceEvent,
  input wire logic [3:0]             chanEvent_q,
  input wire logic [1:0]             capEvent_q,
  input wire logic                   dacStart_q,
  input wire logic                   pwmCutoff_q,
  input wire logic [2*TIMER_W-1:0]   chanCount_q,
  input wire logic [1:0]             chanEnd_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [NUM_SRC-1:0] ev;
  logic [15:0]        hit;
  // Live events per destination code
  always_comb begin
    ev = srcEvent;
    ev[14] = srcEvent[14] | chanEnd_q[0];
    hit = '0;
    for (int n = 0; n < NUM_SRC; n++) begin
      hit[destSel[n*4 +: 4]] = hit[destSel[n*4 +: 4]] | ev[n];
    end
  end
  sequence late2(s);
    ##2 s;
  endsequence
  AST_ADC: assert property (adcTrigger == hit[1])
    else $error("adc trigger wrong");
  AST_CSRC: assert property (countSourceEvent == hit[4])
    else $error("count source wrong");
  AST_CH0: assert property (hit[2] |-> late2(chanEvent_q[0]))
    else $error("chan0 detect late");
  AST_CH3: assert property (hit[9] |-> late2(chanEvent_q[3]))
    else $error("chan3 detect late");
  AST_DAC: assert property (hit[7] |-> late2(dacStart_q))
    else $error("dac start late");
  AST_PWM: assert property (hit[10] |-> late2(pwmCutoff_q))
    else $error("pwm cutoff late");
  AST_CAP: assert property (hit[5] && capClkEn |=> capEvent_q[0])
    else $error("capture detect late");
  AST_IRQ: assert property (1'b1 |=> srcIrq_q == $past(ev))
    else $error("irq path wrong");
  AST_END: assert property (chanEnd_q[0] |->
    chanCount_q[TIMER_W-1:0] == chanReload[TIMER_W-1:0])
    else $error("end without reload");
endmodule
bind event_link_router event_link_router_chk #(.NUM_SRC(NUM_SRC),
  .TIMER_W(TIMER_W)) chk (.sys_clk, .rst, .srcEvent, .destSel, .capClkEn,
  .chanReload, .srcIrq_q, .adcTrigger, .countSourceEvent, .chanEvent_q,
  .capEvent_q, .dacStart_q, .pwmCutoff_q, .chanCount_q, .chanEnd_q);

//--- tb/event_src_model.sv
`timescale 1ns/10ps
module event_src_model #(
  parameter int unsigned N = 26
) (
  input  wire logic         sys_clk,
  input  wire logic [4:0]   idx,
  input  wire logic         fire,
  output logic [N-1:0]      srcEvent
);
  // One-cycle source pulse per request
  initial begin
    srcEvent = '0;
    forever begin
      @(posedge sys_clk);
      srcEvent <= '0;
      if (fire) begin
        srcEvent[idx] <= 1'b1;
      end
    end
  end
endmodule

//--- tb/tb_event_link_router.sv
`timescale 1ns/10ps
module tb_event_link_router;
  logic sys_clk = 0, rst = 1, tauTick = 0, capClkEn = 0, fire = 0;
  logic pwmCutoffClear = 0, adcTrigger, countSourceEvent, dacStart_q;
  logic [25:0] srcEvent, srcIrq_q;
  logic [103:0] destSel = '0;
  logic [4:0] idx = 0;
  logic [1:0] chanEnable = 0, chanMode = 0, capEvent_q, chanEnd_q;
  logic [31:0] chanReload = 0, chanCount_q;
  logic [3:0] chanEvent_q;
  logic pwmCutoff_q;
  int errors = 0, num_checks = 0, ends = 0, ends1 = 0, r, c, s, hi;
  int b0, b1, e0, e1, h1, h2, l1, l2;
  int expQ[$];
  always #4 sys_clk = ~sys_clk;
  // End pulse counters per channel
  always @(posedge sys_clk) begin
    if (chanEnd_q[0] === 1'b1) ends++;
    if (chanEnd_q[1] === 1'b1) ends1++;
  end
  event_src_model src (.sys_clk, .idx, .fire, .srcEvent);
  event_link_router uut (.sys_clk, .rst, .srcEvent, .destSel, .tauTick,
    .chanEnable, .chanMode, .chanReload, .capClkEn, .pwmCutoffClear,
    .srcIrq_q, .adcTrigger, .countSourceEvent, .chanEvent_q, .capEvent_q,
    .dacStart_q, .pwmCutoff_q, .chanCount_q, .chanEnd_q);
  task tick; @(posedge sys_clk); #1; endtask
  // One source pulse; it stands on srcEvent when the task returns
  task pulse(input int i);
    idx = i[4:0];
    fire = 1;
    tick;
    fire = 0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, v);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin #100000; errors++; results; end
  initial begin
    s = $urandom(80);
    repeat (5) tick;
    rst = 0;
    capClkEn = 1;
    for (c = 0; c < 16; c++) begin
      s = $urandom % 13;
      destSel = '0;
      destSel[s*4 +: 4] = c[3:0];
      pulse(s);
      chk("adc", c == 1, adcTrigger);
      chk("csrc", c == 4, countSourceEvent);
      tick;
      chk("irq", 1 << s, srcIrq_q);
      chk("cap", {c == 6, c == 5}, capEvent_q);
      tick;
      chk("chan", {c == 9, c == 8, c == 3, c == 2}, chanEvent_q);
      chk("dac", c == 7, dacStart_q);
      chk("pwm", c == 10, pwmCutoff_q);
      pwmCutoffClear = 1; tick; pwmCutoffClear = 0;
    end
    $display("route table done");
    r = 2 + $urandom % 4;
    chanReload = 32'(r); chanMode = 2'b01;
    destSel = '0; destSel[12 +: 4] = 4'h2;
    tick;
    chanEnable = 2'h1;
    c = r;
    b0 = ends;
    for (int k = 0; k <= r; k++) begin
      c = (c == 0) ? r : c - 1;
      expQ.push_back(c);
    end
    for (int k = 0; k <= r; k++) begin
      pulse(3);
      repeat (3) tick;
      chk("cnt0", expQ.pop_front(), chanCount_q[15:0]);
    end
    tick;
    chk("ends", 1, ends - b0);
    $display("event count done");
    chanEnable = 0; chanMode = 2'b10; chanReload = 32'h0005_0001;
    destSel = '0; destSel[56 +: 4] = 4'h3;
    tick;
    b0 = ends;
    b1 = ends1;
    chanEnable = 2'h3;
    tauTick = 1;
    repeat (20) tick;
    tauTick = 0;
    repeat (4) tick;
    c = 1;
    hi = 5;
    e0 = 0;
    e1 = 0;
    repeat (20) begin
      if (c == 0) begin
        c = 1;
        e0++;
        if (hi == 0) begin
          hi = 5;
          e1++;
        end else begin
          hi--;
        end
      end else begin
        c--;
      end
    end
    chk("lo", c, chanCount_q[15:0]);
    chk("hi", hi, chanCount_q[31:16]);
    chk("ends0", e0, ends - b0);
    chk("ends1", e1, ends1 - b1);
    h1 = chanCount_q[31:16];
    l1 = chanCount_q[15:0];
    tick;
    h2 = chanCount_q[31:16];
    l2 = chanCount_q[15:0];
    s = (h1 == h2) ? ((h1 << 16) | l1) : ((h2 << 16) | l2);
    chk("read32", {hi[15:0], c[15:0]}, s);
    $display("cascade done");
    capClkEn = 0;
    destSel = '0;
    destSel[0 +: 4] = event_link_pkg::DEST_CAPB;
    pulse(0);
    repeat (2) tick;
    chk("capHold", 2'h0, capEvent_q);
    capClkEn = 1;
    tick;
    chk("capLate", 2'h2, capEvent_q);
    tick;
    chk("capDone", 2'h0, capEvent_q);
    destSel[0 +: 4] = event_link_pkg::DEST_PWM;
    pwmCutoffClear = 1;
    pulse(0);
    repeat (2) tick;
    chk("pwmSet", 1, pwmCutoff_q);
    tick;
    chk("pwmClr", 0, pwmCutoff_q);
    pwmCutoffClear = 0;
    $display("capture and cutoff done");
    rst = 1;
    tick;
    chk("rstCnt", 0, chanCount_q);
    chk("rstIrq", 0, srcIrq_q);
    rst = 0;
    tick;
    chk("rstRun", 0, chanCount_q);
    $display("reset done");
    results;
  end
endmodule
